/* File: tsvc_pkg.sv */
// tsvc_pkg: register indices, field layout, reset values and carriers
// for the tuner seek, band, volume and soft-mute configuration words.
// assumes a 16-bit register port addressed by register index.
package tsvc_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // register indices as the host addresses them
   localparam logic [7:0] REG_IDX_SBV  = 8'h05;
   localparam logic [7:0] REG_IDX_SMQ  = 8'h06;
   localparam logic [7:0] REG_IDX_STAT = 8'h10;

   localparam logic [15:0] SBV_RESET  = 16'h0000;
   localparam logic [15:0] SMQ_RESET  = 16'h0000;
   localparam logic [15:0] READ_UNMAP = 16'h0000;

   // seek_band_volume_config fields
   localparam int SBV_STRENGTH_LSB = 8;
   localparam int SBV_BAND_LSB   = 6;
   localparam int SBV_SPACE_LSB  = 4;
   localparam int SBV_VOL_LSB    = 0;

   // softmute_seek_quality_config fields
   localparam int SMQ_RATE_LSB  = 14;
   localparam int SMQ_DEPTH_LSB = 12;
   localparam int SMQ_RSVD_LSB  = 9;
   localparam int SMQ_VOLX_BIT  = 8;
   localparam int SMQ_SNR_LSB   = 4;
   localparam int SMQ_IMP_LSB   = 0;

   // status word layout
   localparam int STAT_PASS_BIT  = 0;
   localparam int STAT_RSSI_BIT  = 1;
   localparam int STAT_SNR_BIT   = 2;
   localparam int STAT_IMP_BIT   = 3;
   localparam int STAT_BAND_BIT  = 4;
   localparam int STAT_DONE_BIT  = 5;
   localparam int STAT_SEEK_BIT  = 6;

   localparam logic [1:0] BAND_WIDE_EU = 2'b00;
   localparam logic [1:0] BAND_WIDE_JP = 2'b01;
   localparam logic [1:0] BAND_JAPAN   = 2'b10;
   localparam logic [1:0] SPACE_200    = 2'b00;
   localparam logic [1:0] SPACE_100    = 2'b01;
   localparam logic [1:0] SPACE_50     = 2'b10;

   localparam int FREQ_W = 20;
   localparam logic [19:0] BASE_EU_KHZ = 20'h155CC;
   localparam logic [19:0] BASE_JP_KHZ = 20'h128E0;
   localparam logic [19:0] TOP_WIDE_KHZ = 20'h1A5E0;
   localparam logic [19:0] TOP_JP_KHZ  = 20'h15F90;
   localparam logic [7:0] STEP_200_KHZ = 8'hC8;
   localparam logic [7:0] STEP_100_KHZ = 8'h64;
   localparam logic [7:0] STEP_50_KHZ  = 8'h32;

   localparam logic [3:0] VOL_MUTE_CODE = 4'h0;
   localparam logic [3:0] VOL_TOP_CODE  = 4'hF;
   localparam logic [5:0] VOL_STEP_DB   = 6'h02;
   localparam logic [5:0] VOL_EXT_DB    = 6'h1E;
   localparam logic [4:0] SMUTE_BASE_DB = 5'h10;
   localparam logic [4:0] SMUTE_STEP_DB = 5'h02;
   localparam logic [3:0] CHECK_OFF     = 4'h0;
   localparam logic [4:0] IMP_SPAN      = 5'h10;

   typedef struct packed {
      logic [7:0] seek_strength_threshold;
      logic [1:0] band;
      logic [1:0] spacing;
      logic [3:0] volume;
      logic [1:0] softmute_rate;
      logic [1:0] softmute_depth;
      logic       extended_volume_range;
      logic [3:0] seek_snr_threshold;
      logic [3:0] seek_impulse_threshold;
   } tsvc_cfg_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] rssi;
      logic [3:0] snr;
      logic [3:0] impulses;
   } tsvc_meas_s;

   function automatic logic [7:0] tsvc_step_khz(input logic [1:0] sp);
      case (sp)
         SPACE_100: tsvc_step_khz = STEP_100_KHZ;
         SPACE_50:  tsvc_step_khz = STEP_50_KHZ;
         default:   tsvc_step_khz = STEP_200_KHZ;
      endcase
   endfunction : tsvc_step_khz

   function automatic logic [19:0] tsvc_base_khz(input logic [1:0] bd);
      if (bd == BAND_WIDE_JP || bd == BAND_JAPAN) begin
         tsvc_base_khz = BASE_JP_KHZ;
      end else begin
         tsvc_base_khz = BASE_EU_KHZ;
      end
   endfunction : tsvc_base_khz

   function automatic logic [19:0] tsvc_top_khz(input logic [1:0] bd);
      tsvc_top_khz = (bd == BAND_JAPAN) ? TOP_JP_KHZ : TOP_WIDE_KHZ;
   endfunction : tsvc_top_khz

endpackage : tsvc_pkg

/* File: tsvc_seek_qual.sv */
// tsvc_seek_qual: judges one seek candidate against the programmed
// strength, snr and impulse thresholds.
// assumes measurements arrive on clk with a one-cycle valid.
`timescale 1ns/10ps
module tsvc_seek_qual (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              seek_active,
   input  wire logic [7:0]        strength_thr,
   input  wire logic [3:0]        snr_thr,
   input  wire logic [3:0]        impulse_thr,
   input  wire tsvc_pkg::tsvc_meas_s meas,
   output logic                   qual_done,
   output logic                   qual_pass,
   output logic [2:0]             qual_reject
);
   import tsvc_pkg::*;

   logic rssi_bad;
   logic snr_bad;
   logic imp_bad;

   // disabled checks never reject
   assign rssi_bad = meas.rssi < strength_thr;
   assign snr_bad  = (snr_thr != CHECK_OFF) && (meas.snr < snr_thr);
   // larger code allows fewer impulses: code 1 allows 15, code 15 allows 1
   assign imp_bad  = (impulse_thr != CHECK_OFF) &&
                     ({1'b0, meas.impulses} > (IMP_SPAN - {1'b0, impulse_thr}));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qual_done <= 1'b0;
      end else begin
         qual_done <= seek_active && meas.valid;
      end
   end

   // verdict holds until the next judged candidate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qual_pass   <= 1'b0;
         qual_reject <= 3'b000;
      end else if (seek_active && meas.valid) begin
         qual_pass   <= !(rssi_bad || snr_bad || imp_bad);
         qual_reject <= {imp_bad, snr_bad, rssi_bad};
      end
   end

endmodule : tsvc_seek_qual

/* File: tsvc_regs.sv */
// tsvc_regs: two 16-bit configuration words for seek quality, band,
// spacing, volume and soft-mute, plus the outputs derived from them.
// assumes a single-cycle register port on clk and measurements on clk.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module tsvc_regs (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic [tsvc_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [tsvc_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [tsvc_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic [9:0]                  channel_number,
   input  wire logic                        seek_active,
   input  wire tsvc_pkg::tsvc_meas_s        meas,
   output logic [tsvc_pkg::FREQ_W-1:0]      tuned_freq_khz,
   output logic                             freq_in_band,
   output logic                             vol_mute,
   output logic [5:0]                       vol_atten_db,
   output logic [1:0]                       softmute_rate,
   output logic [4:0]                       softmute_depth_db,
   output logic                             seek_done,
   output logic                             seek_pass,
   output logic [2:0]                       seek_reject
);
   import tsvc_pkg::*;

   logic [15:0]      sbv_r;
   logic [15:0]      smq_r;
   tsvc_cfg_s        cfg;
   logic [15:0]      stat_word;
   logic [15:0]      rdata_nxt;
   logic             wr_sbv;
   logic             wr_smq;
   logic             last_done_r;

   logic [19:0]      offset_khz;
   logic [19:0]      freq_nxt;
   logic             band_ok_nxt;
   logic [5:0]       atten_nxt;

   logic             qual_done;
   logic             qual_pass;
   logic [2:0]       qual_reject;

   assign wr_sbv = reg_wr && (reg_addr == REG_IDX_SBV);
   assign wr_smq = reg_wr && (reg_addr == REG_IDX_SMQ);

   // seek_band_volume_config, every bit read/write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sbv_r <= SBV_RESET;
      end else if (wr_sbv) begin
         sbv_r <= reg_wdata;
      end
   end

   // reserved bits are not stored, so they read zero whatever is written
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         smq_r <= SMQ_RESET;
      end else if (wr_smq) begin
         smq_r <= reg_wdata & ~(16'h0007 << SMQ_RSVD_LSB);
      end
   end

   // field view of both words
   always_comb begin
      cfg.seek_strength_threshold = sbv_r[SBV_STRENGTH_LSB +: 8];
      cfg.band                    = sbv_r[SBV_BAND_LSB +: 2];
      cfg.spacing                 = sbv_r[SBV_SPACE_LSB +: 2];
      cfg.volume                  = sbv_r[SBV_VOL_LSB +: 4];
      cfg.softmute_rate           = smq_r[SMQ_RATE_LSB +: 2];
      cfg.softmute_depth          = smq_r[SMQ_DEPTH_LSB +: 2];
      cfg.extended_volume_range   = smq_r[SMQ_VOLX_BIT];
      cfg.seek_snr_threshold      = smq_r[SMQ_SNR_LSB +: 4];
      cfg.seek_impulse_threshold  = smq_r[SMQ_IMP_LSB +: 4];
   end

   // tuned frequency; 10-bit channel times 8-bit step fits 18 bits
   always_comb begin
      offset_khz = {2'b00, 18'(channel_number * tsvc_step_khz(cfg.spacing))};
      freq_nxt   = 20'(tsvc_base_khz(cfg.band) + offset_khz);
      // reserved band never counts as in band
      band_ok_nxt = (cfg.band != 2'b11) &&
                    (freq_nxt <= tsvc_top_khz(cfg.band));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tuned_freq_khz <= BASE_EU_KHZ;
         freq_in_band   <= 1'b1;
      end else begin
         tuned_freq_khz <= freq_nxt;
         freq_in_band   <= band_ok_nxt;
      end
   end

   // attenuation below full scale in dB; 2 dB per code step
   always_comb begin
      atten_nxt = 6'((VOL_TOP_CODE - cfg.volume) * VOL_STEP_DB);
      if (cfg.extended_volume_range) begin
         atten_nxt = 6'(atten_nxt + VOL_EXT_DB);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vol_mute     <= 1'b1;
         vol_atten_db <= 6'h00;
      end else begin
         vol_mute     <= (cfg.volume == VOL_MUTE_CODE);
         vol_atten_db <= atten_nxt;
      end
   end

   // depth falls 2 dB per code from 16 dB
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         softmute_rate     <= 2'b00;
         softmute_depth_db <= SMUTE_BASE_DB;
      end else begin
         softmute_rate     <= cfg.softmute_rate;
         softmute_depth_db <= 5'(SMUTE_BASE_DB -
                              cfg.softmute_depth * SMUTE_STEP_DB);
      end
   end

   tsvc_seek_qual u_qual (
      .clk          (clk),
      .rst_n        (rst_n),
      .seek_active  (seek_active),
      .strength_thr (cfg.seek_strength_threshold),
      .snr_thr      (cfg.seek_snr_threshold),
      .impulse_thr  (cfg.seek_impulse_threshold),
      .meas         (meas),
      .qual_done    (qual_done),
      .qual_pass    (qual_pass),
      .qual_reject  (qual_reject)
   );

   // retimed so top outputs come straight from local flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seek_done   <= 1'b0;
         seek_pass   <= 1'b0;
         seek_reject <= 3'b000;
      end else begin
         seek_done   <= qual_done;
         seek_pass   <= qual_pass;
         seek_reject <= qual_reject;
      end
   end

   // sticky until the status word is read; a new verdict beats the read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_done_r <= 1'b0;
      end else if (qual_done) begin
         last_done_r <= 1'b1;
      end else if (reg_rd && reg_addr == REG_IDX_STAT) begin
         last_done_r <= 1'b0;
      end
   end

   always_comb begin
      stat_word                = 16'h0000;
      stat_word[STAT_PASS_BIT] = seek_pass;
      stat_word[STAT_RSSI_BIT] = seek_reject[0];
      stat_word[STAT_SNR_BIT]  = seek_reject[1];
      stat_word[STAT_IMP_BIT]  = seek_reject[2];
      stat_word[STAT_BAND_BIT] = freq_in_band;
      stat_word[STAT_DONE_BIT] = last_done_r;
      stat_word[STAT_SEEK_BIT] = seek_active;
   end

   always_comb begin
      unique case (reg_addr)
         REG_IDX_SBV:  rdata_nxt = sbv_r;
         REG_IDX_SMQ:  rdata_nxt = smq_r;
         REG_IDX_STAT: rdata_nxt = stat_word;
         default:      rdata_nxt = READ_UNMAP;
      endcase
   end

   // data stand one cycle only, zero otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule : tsvc_regs

/* File: tsvc_regs_props.sv */
// tsvc_regs_props: port-level checks for tsvc_regs.
// assumes one clock domain and the async active-low reset.
`timescale 1ns/10ps
module tsvc_regs_props
   import tsvc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [9:0]  channel_number,
   input wire logic        seek_active,
   input wire tsvc_pkg::tsvc_meas_s meas,
   input wire logic [19:0] tuned_freq_khz,
   input wire logic        freq_in_band,
   input wire logic        vol_mute,
   input wire logic [5:0]  vol_atten_db,
   input wire logic [1:0]  softmute_rate,
   input wire logic [4:0]  softmute_depth_db,
   input wire logic        seek_done,
   input wire logic        seek_pass,
   input wire logic [2:0]  seek_reject
);
   logic [15:0] sbv_r, smq_r, rd_k;
   logic [19:0] base_k, freq_k;
   logic [7:0]  step_k;
   logic [5:0]  att_k;
   logic [4:0]  dep_k;
   logic [2:0]  rej_k;
   logic        inb_k, cand_w, rd_w;
   // shadow copies, so no view of the bodies is needed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sbv_r <= 16'h0000;
      else if (reg_wr && reg_addr == REG_IDX_SBV) sbv_r <= reg_wdata;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) smq_r <= 16'h0000;
      else if (reg_wr && reg_addr == REG_IDX_SMQ)
         smq_r <= reg_wdata & 16'hF1FF;
   end
   always_comb begin
      base_k = (sbv_r[7:6] == BAND_WIDE_JP || sbv_r[7:6] == BAND_JAPAN) ?
               BASE_JP_KHZ : BASE_EU_KHZ;
      step_k = (sbv_r[5:4] == SPACE_100) ? STEP_100_KHZ :
               (sbv_r[5:4] == SPACE_50) ? STEP_50_KHZ : STEP_200_KHZ;
      freq_k = base_k + 20'(step_k) * 20'(channel_number);
      inb_k  = sbv_r[7:6] != 2'h3 && freq_k <=
               ((sbv_r[7:6] == BAND_JAPAN) ? TOP_JP_KHZ : TOP_WIDE_KHZ);
      att_k  = 6'((4'hF - sbv_r[3:0]) * 6'h2) + (smq_r[8] ? 6'h1E : 6'h00);
      dep_k  = 5'h10 - {2'h0, smq_r[13:12], 1'h0};
      rej_k  = {smq_r[3:0] != 4'h0 &&
                {1'h0, meas.impulses} > 5'h10 - smq_r[3:0],
                smq_r[7:4] != 4'h0 && meas.snr < smq_r[7:4],
                meas.rssi < sbv_r[15:8]};
      rd_k   = (reg_addr == REG_IDX_SBV) ? sbv_r :
               (reg_addr == REG_IDX_SMQ) ? smq_r : 16'h0000;
   end
   assign cand_w = meas.valid && seek_active;
   assign rd_w   = reg_rd && reg_addr != REG_IDX_STAT;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence cand_s;
      cand_w;
   endsequence
   sequence judged_s;
      ##2 seek_done && seek_reject == $past(rej_k, 2);
   endsequence
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not cleared");
   rd_back_a: assert property ($past(rd_w) |-> reg_rdata == $past(rd_k))
      else $error("read data wrong");
   freq_calc_a: assert property (tuned_freq_khz ==
      ($past(rst_n) ? $past(freq_k) : BASE_EU_KHZ))
      else $error("tuned frequency wrong");
   in_band_a: assert property (freq_in_band ==
      (!$past(rst_n) || $past(inb_k))) else $error("band limit flag wrong");
   vol_mute_a: assert property (vol_mute == ($past(sbv_r[3:0]) == 4'h0))
      else $error("mute flag wrong");
   vol_atten_a: assert property (!vol_mute |-> vol_atten_db == $past(att_k))
      else $error("attenuation wrong");
   soft_mute_a: assert property (softmute_depth_db == $past(dep_k) &&
      softmute_rate == $past(smq_r[15:14])) else $error("soft mute wrong");
   seek_verdict_a: assert property (cand_s |-> judged_s)
      else $error("seek verdict wrong");
   seek_pass_a: assert property (seek_done |-> seek_pass == (seek_reject == 3'h0))
      else $error("pass disagrees with reject bits");
   done_cause_a: assert property (seek_done |-> $past(cand_w, 2))
      else $error("seek done without candidate");
   verdict_hold_a: assert property (!seek_done |->
      $stable(seek_pass) && $stable(seek_reject)) else $error("verdict moved");
endmodule : tsvc_regs_props

bind tsvc_regs tsvc_regs_props u_props (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .channel_number(channel_number), .seek_active(seek_active), .meas(meas),
   .tuned_freq_khz(tuned_freq_khz), .freq_in_band(freq_in_band),
   .vol_mute(vol_mute), .vol_atten_db(vol_atten_db),
   .softmute_rate(softmute_rate), .softmute_depth_db(softmute_depth_db),
   .seek_done(seek_done), .seek_pass(seek_pass), .seek_reject(seek_reject));

/* File: tsvc_host_model.sv */
// tsvc_host_model: host side of the register port, one access per task.
// assumes the block answers reads one cycle after the strobe edge.
`timescale 1ns/10ps
module tsvc_host_model (
   input  wire logic [tsvc_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                        clk,
   output logic      [tsvc_pkg::ADDR_W-1:0] reg_addr,
   output logic      [tsvc_pkg::DATA_W-1:0] reg_wdata,
   output logic                             reg_wr,
   output logic                             reg_rd
);
   import tsvc_pkg::*;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= (a == REG_IDX_SMQ) ? (d & 16'hF1FF) : d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
      // idle bus shows junk, not the last word
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      reg_addr <= ~a;
      @(posedge clk);
      d = reg_rdata;
   endtask : rd
endmodule : tsvc_host_model

/* File: tb_top.sv */
// tb_top: self-checking bench for tsvc_regs with a host model.
// assumes the checker is bound in from its own file.
`timescale 1ns/10ps
module tb_top;
   import tsvc_pkg::*;
   logic             clk, rst_n, reg_wr, reg_rd, seek_active;
   logic [7:0]       reg_addr;
   logic [15:0]      reg_wdata, reg_rdata, rv;
   logic [9:0]       channel_number;
   tsvc_meas_s       meas;
   logic [19:0]      tuned_freq_khz, ef;
   logic             freq_in_band, vol_mute, seek_done, seek_pass;
   logic [5:0]       vol_atten_db;
   logic [1:0]       softmute_rate;
   logic [4:0]       softmute_depth_db;
   logic [2:0]       seek_reject;
   int               err_count, n_checks;
   tsvc_host_model host (.clk(clk), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd));
   tsvc_regs DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .channel_number(channel_number),
      .seek_active(seek_active), .meas(meas),
      .tuned_freq_khz(tuned_freq_khz), .freq_in_band(freq_in_band),
      .vol_mute(vol_mute), .vol_atten_db(vol_atten_db),
      .softmute_rate(softmute_rate), .softmute_depth_db(softmute_depth_db),
      .seek_done(seek_done), .seek_pass(seek_pass),
      .seek_reject(seek_reject));
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   task automatic t_reset;
      host.wr(REG_IDX_SBV, 16'hFFFF);
      host.wr(REG_IDX_SMQ, 16'hFFFF);
      @(posedge clk) rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      settle(1);
      check("freq", tuned_freq_khz, 20'h155CC + 20'h3E8);
      check("mute", vol_mute, 1'h1);
      check("depth", softmute_depth_db, 5'h10);
      host.rd(REG_IDX_SBV, rv);
      check("sbv", rv, 16'h0000);
      host.rd(REG_IDX_SMQ, rv);
      check("smq", rv, 16'h0000);
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs;
      host.wr(REG_IDX_SBV, 16'h7FA5);
      host.wr(REG_IDX_SMQ, 16'hFFFF);
      host.wr(8'h07, 16'h1234);
      host.rd(REG_IDX_SBV, rv);
      check("sbv", rv, 16'h7FA5);
      host.rd(REG_IDX_SMQ, rv);
      check("smq", rv, 16'hF1FF);
      host.rd(8'h07, rv);
      check("unmapped", rv, 16'h0000);
      $display("test regs done");
   endtask : t_regs
   task automatic t_band;
      logic [1:0] b, s;
      @(posedge clk) channel_number <= 10'h064;
      for (int i = 0; i < 12; i++) begin
         b = 2'(i / 3);
         s = 2'(i % 3);
         host.wr(REG_IDX_SBV, {8'h00, b, s, 4'h8});
         settle(2);
         ef = ((b == 2'h1 || b == 2'h2) ? 20'h128E0 : 20'h155CC) +
              ((s == 2'h1) ? 20'h2710 : (s == 2'h2) ? 20'h1388 : 20'h4E20);
         check("freq", tuned_freq_khz, ef);
         check("band", freq_in_band, b != 2'h3 &&
               ef <= ((b == 2'h2) ? 20'h15F90 : 20'h1A5E0));
      end
      // band edge: last channel inside 76-90 at 50 kHz
      host.wr(REG_IDX_SBV, 16'h00A8);
      for (int c = 0; c < 2; c++) begin
         @(posedge clk) channel_number <= 10'h118 + 10'(c);
         settle(2);
         check("edge", freq_in_band, c == 0);
      end
      $display("test band done");
   endtask : t_band
   task automatic t_vol;
      logic [3:0] v;
      for (int i = 0; i < 32; i++) begin
         v = 4'(i);
         host.wr(REG_IDX_SMQ, {v[1:0], v[3:2], 3'h0, i[4], 8'h00});
         host.wr(REG_IDX_SBV, {12'h000, v});
         settle(2);
         check("mute", vol_mute, v == 4'h0);
         if (v != 4'h0)
            check("atten", vol_atten_db, (15 - v) * 2 + 30 * i[4]);
         check("rate", softmute_rate, v[1:0]);
         check("depth", softmute_depth_db, 16 - 2 * v[3:2]);
      end
      $display("test volume done");
   endtask : t_vol
   task automatic cand(input logic act, input logic [15:0] m,
                       input logic [2:0] rj);
      @(posedge clk);
      meas <= {1'h1, m};
      seek_active <= act;
      @(posedge clk);
      meas.valid <= 1'h0;
      // done stands for one cycle only, one edge after the taken edge
      settle(1);
      check("done", seek_done, act);
      if (act) check("reject", seek_reject, rj);
      if (act) check("pass", seek_pass, rj == 3'h0);
   endtask : cand
   task automatic t_seek;
      logic [19:0] tab [5] = '{20'h40_5_C_0, 20'h3F_5_C_1, 20'h40_4_C_2,
                               20'h40_5_D_4, 20'h00_0_F_7};
      for (int p = 0; p < 2; p++) begin
         host.wr(REG_IDX_SBV, p ? 16'h0000 : 16'h4000);
         host.wr(REG_IDX_SMQ, p ? 16'h0000 : 16'h0054);
         foreach (tab[k]) cand(1'h1, tab[k][19:4], p ? 3'h0 : tab[k][2:0]);
      end
      // sticky judged flag clears on the status read that reports it
      host.rd(REG_IDX_STAT, rv);
      check("status", rv, 16'h0061);
      host.rd(REG_IDX_STAT, rv);
      check("status", rv, 16'h0041);
      cand(1'h0, 16'h0000, 3'h0);
      $display("test seek done");
   endtask : t_seek
   initial begin
      rst_n = 1'h0;
      channel_number = 10'h005;
      seek_active = 1'h0;
      meas = '0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      t_reset;
      t_regs;
      t_band;
      t_vol;
      t_seek;
      report_and_stop;
   end
   initial begin
      #100000;
      err_count++;
      report_and_stop;
   end
endmodule : tb_top
